// ==== cbo_pkg.sv ====
// Shared constants for the clock buffer output enable control pair.
// Assumes a 100 MHz core clock and a two-wire link at about 400 kHz.
package cbo_pkg;
  // Target address, seven bits without the direction bit
  localparam logic [6:0] TGT_ADDR7 = 7'h6B;
  localparam int NUM_REGS = 6;
  localparam int NUM_OUT  = 6;
  // Register offsets
  localparam logic [7:0] REG_RSVD = 8'h00;
  localparam logic [7:0] REG_OE_LO = 8'h01;
  localparam logic [7:0] REG_OE_HI = 8'h02;
  localparam logic [7:0] REG_REV = 8'h03;
  localparam logic [7:0] REG_BCNT = 8'h04;
  localparam logic [7:0] REG_AMP = 8'h05;
  // Reset values
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_OE_LO = 8'h15;
  localparam logic [7:0] RST_OE_HI = 8'hE0;
  localparam logic [7:0] RST_BCNT = 8'h06;
  localparam logic [7:0] RST_AMP = 8'hD8;
  // Enable bit of each output: register offset and bit position
  localparam int OE_BYTE [NUM_OUT] = '{1, 1, 1, 2, 2, 2};
  localparam int OE_BIT  [NUM_OUT] = '{4, 2, 0, 7, 6, 5};
  // Amplitude fields
  localparam int AMP_SEL_POS = 7;
  localparam int AMP_LVL_LSB = 4;
  localparam int AMP_LVL_W   = 3;
  // Command code bit that selects block access
  localparam int CMD_BLOCK_BIT = 7;
  // Link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // Controller operations
  typedef enum logic [1:0] {OP_BYTE_WR, OP_BYTE_RD, OP_BLK_WR, OP_BLK_RD} cbo_op_t;
endpackage : cbo_pkg

// ==== cbo_link_if.sv ====
// Two-wire link between controller and clock buffer target.
// Assumes open-drain data; the wire level is resolved here from enables.
`timescale 1ns/1ps
interface cbo_link_if;
  logic scl;          // Clock, driven by the controller only
  logic sda_dev_o;    // Target data out
  logic sda_dev_oe;   // Target drives data
  logic sda_host_o;   // Controller data out
  logic sda_host_oe;  // Controller drives data
  logic sda;          // Resolved wire level, pulled up when idle
  // Wired-and of both drivers
  assign sda = !((sda_dev_oe && !sda_dev_o) || (sda_host_oe && !sda_host_o));
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
  modport host (output scl, input sda, output sda_host_o, output sda_host_oe);
endinterface : cbo_link_if

// ==== cbo_target.sv ====
// Clock buffer target: two-wire register slave plus six gated clock outputs.
// Assumes clk is the core clock and ref_clk the buffered input clock.
// Operation
// - Output runs only when pin and bit high
// - Controller side drives enable pins always
// - Outputs stop and start independently, synchronously
// - Restart without short or stretched pulses
// - Output active two to six cycles later
// - Disabled output stops driven low
// - Registers load defaults at reset
// - Enable changes accepted only in program mode
// - Byte and block, read and write supported
// - Block bytes ascending, msb first, stop anywhere
// - Byte access indexed by command code
// - Answer only address D6h
// - Block write sequence, every byte acknowledged
// - Block read returns count then data
// - Byte write acknowledges address, command, data
// - Byte read returns one refused byte
// - Byte 1 holds enables 0 to 2
// - Byte 2 holds enables 3 to 5
// - Byte 5 selects and sets amplitude
`timescale 1ns/1ps
module cbo_target #(
  parameter logic [7:0] REV_MAKER_RST = 8'h5A  // Arbitrary identity value
) (
  // Link
  cbo_link_if.dev          link,
  // Core clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Buffered input clock
  input  wire logic        ref_clk,
  // Pins
  input  wire logic [5:0]  oe_pin,
  input  wire logic        pm_prog,
  // Outputs
  output logic [5:0]       clock_out,
  output logic             amp_override,
  output logic [2:0]       amp_level
);
  typedef enum {T_IDLE, T_ADDR, T_CMD, T_WRITE, T_READ} cbo_tst_t;

  logic [1:0] scl_s_r;    // Clock synchroniser
  logic [1:0] sda_s_r;    // Data synchroniser
  logic [1:0] prg_s_r;    // Program mode synchroniser
  logic       scl_d_r;    // Delayed clock for edges
  logic       sda_d_r;    // Delayed data for edges

  // Pin synchronisers; first stages read only by second stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      prg_s_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      prg_s_r <= {prg_s_r[0], pm_prog};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  logic sda_now;      // Synchronised data
  logic scl_rise;     // Clock rising edge
  logic scl_fall;     // Clock falling edge
  logic start_det;    // Start or repeated start
  logic stop_det;     // Stop
  assign sda_now   = sda_s_r[1];
  assign scl_rise  = scl_s_r[1] && !scl_d_r;
  assign scl_fall  = !scl_s_r[1] && scl_d_r;
  assign start_det = scl_s_r[1] && scl_d_r && sda_d_r && !sda_now;
  assign stop_det  = scl_s_r[1] && scl_d_r && !sda_d_r && sda_now;

  cbo_tst_t   st_r, st_nxt;           // Target state
  logic [7:0] sh_r, sh_nxt;           // Shift register
  logic [2:0] bitc_r, bitc_nxt;       // Bit counter
  logic       ackph_r, ackph_nxt;     // In acknowledge slot
  logic       bdone_r, bdone_nxt;     // Byte just completed
  logic       dack_r, dack_nxt;       // Acknowledge the byte
  logic       block_r, block_nxt;     // Block access
  logic       first_r, first_nxt;     // Next byte is the count
  logic [7:0] idx_r, idx_nxt;         // Register index
  logic       oe_r, oe_nxt;           // Data pulled low
  logic [7:0] rf_r [cbo_pkg::NUM_REGS];        // Register file
  logic [7:0] rf_nxt [cbo_pkg::NUM_REGS];

  // Read mux; unmapped indices read zero
  function automatic logic [7:0] rd_byte(input logic [7:0] i,
                                         input logic [7:0] f [cbo_pkg::NUM_REGS]);
    rd_byte = (i < 8'(cbo_pkg::NUM_REGS)) ? f[i[2:0]] : 8'h00;
  endfunction : rd_byte

  // Target next state
  always_comb begin
    logic [7:0] b;
    logic [7:0] v;
    logic       wok;
    b = {sh_r[6:0], sda_now};
    v = 8'h00;
    wok = 1'b0;
    st_nxt = st_r;
    sh_nxt = sh_r;
    bitc_nxt = bitc_r;
    ackph_nxt = ackph_r;
    bdone_nxt = bdone_r;
    dack_nxt = dack_r;
    block_nxt = block_r;
    first_nxt = first_r;
    idx_nxt = idx_r;
    oe_nxt = oe_r;
    rf_nxt = rf_r;
    if (start_det) begin
      // Start keeps the index for a following read
      st_nxt = T_ADDR;
      bitc_nxt = 3'h0;
      ackph_nxt = 1'b0;
      bdone_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (stop_det) begin
      st_nxt = T_IDLE;
      ackph_nxt = 1'b0;
      bdone_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (scl_rise && st_r != T_IDLE) begin
      if (ackph_r) begin
        if (st_r == T_READ && sda_now) begin
          st_nxt = T_IDLE;
        end
      end else if (st_r == T_READ) begin
        // Controller samples our bit here
        bitc_nxt = 3'(bitc_r + 3'h1);
        if (bitc_r == 3'h7) begin
          bdone_nxt = 1'b1;
          dack_nxt = 1'b0;
        end
      end else begin
        sh_nxt = b;
        bitc_nxt = 3'(bitc_r + 3'h1);
        if (bitc_r == 3'h7) begin
          bdone_nxt = 1'b1;
          dack_nxt = 1'b1;
          case (st_r)
            T_ADDR: begin
              if (b[7:1] == cbo_pkg::TGT_ADDR7) begin
                // direction bit picks read or write
                st_nxt = b[0] ? T_READ : T_CMD;
              end else begin
                st_nxt = T_IDLE;
                dack_nxt = 1'b0;
              end
            end
            T_CMD: begin
              block_nxt = b[cbo_pkg::CMD_BLOCK_BIT];
              idx_nxt = block_nxt ? {1'b0, b[6:0]} : b;
              first_nxt = 1'b1;
              st_nxt = T_WRITE;
            end
            T_WRITE: begin
              if (block_r && first_r) begin
                first_nxt = 1'b0;
              end else begin
                if (idx_r == cbo_pkg::REG_OE_LO || idx_r == cbo_pkg::REG_OE_HI) begin
                  wok = prg_s_r[1];
                end else begin
                  wok = idx_r < 8'(cbo_pkg::NUM_REGS);
                end
                if (wok) begin
                  rf_nxt[idx_r[2:0]] = b;
                end
                idx_nxt = 8'(idx_r + 8'h01);
              end
            end
            default: begin
              st_nxt = T_IDLE;
            end
          endcase
        end
      end
    end else if (scl_fall) begin
      if (ackph_r) begin
        // Leave the acknowledge slot
        ackph_nxt = 1'b0;
        oe_nxt = 1'b0;
        if (st_r == T_READ) begin
          if (block_r && first_r) begin
            v = rf_r[cbo_pkg::REG_BCNT[2:0]];
            first_nxt = 1'b0;
          end else begin
            v = rd_byte(idx_r, rf_r);
            idx_nxt = 8'(idx_r + 8'h01);
          end
          sh_nxt = v;
          oe_nxt = !v[7];
          bitc_nxt = 3'h0;
        end
      end else if (bdone_r) begin
        bdone_nxt = 1'b0;
        ackph_nxt = 1'b1;
        oe_nxt = dack_r;
      end else if (st_r == T_READ) begin
        sh_nxt = {sh_r[6:0], 1'b0};
        oe_nxt = !sh_r[6];
      end
    end
  end

  // Target registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= T_IDLE;
      sh_r <= 8'h00;
      bitc_r <= 3'h0;
      ackph_r <= 1'b0;
      bdone_r <= 1'b0;
      dack_r <= 1'b0;
      block_r <= 1'b0;
      first_r <= 1'b0;
      idx_r <= 8'h00;
      oe_r <= 1'b0;
      rf_r[0] <= cbo_pkg::RST_RSVD;
      rf_r[1] <= cbo_pkg::RST_OE_LO;
      rf_r[2] <= cbo_pkg::RST_OE_HI;
      rf_r[3] <= REV_MAKER_RST;
      rf_r[4] <= cbo_pkg::RST_BCNT;
      rf_r[5] <= cbo_pkg::RST_AMP;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bitc_r <= bitc_nxt;
      ackph_r <= ackph_nxt;
      bdone_r <= bdone_nxt;
      dack_r <= dack_nxt;
      block_r <= block_nxt;
      first_r <= first_nxt;
      idx_r <= idx_nxt;
      oe_r <= oe_nxt;
      rf_r <= rf_nxt;
    end
  end

  logic       sdo_r;           // Open drain data level, always low
  logic [5:0] en_r, en_nxt;    // Register enable bits, core domain
  logic       ampo_r;          // Amplitude override
  logic [2:0] ampl_r;          // Amplitude level

  // Enable bits and amplitude, held in flops for crossing
  always_comb begin
    for (int i = 0; i < cbo_pkg::NUM_OUT; i++) begin
      // low byte enables; high byte enables
      en_nxt[i] = rf_r[cbo_pkg::OE_BYTE[i]][cbo_pkg::OE_BIT[i]];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sdo_r <= 1'b0;
      en_r <= 6'h00;
      ampo_r <= 1'b0;
      ampl_r <= 3'h0;
    end else begin
      sdo_r <= 1'b0;
      en_r <= en_nxt;
      ampo_r <= rf_r[cbo_pkg::REG_AMP[2:0]][cbo_pkg::AMP_SEL_POS];
      ampl_r <= rf_r[cbo_pkg::REG_AMP[2:0]][cbo_pkg::AMP_LVL_LSB +: cbo_pkg::AMP_LVL_W];
    end
  end

  assign link.sda_dev_o  = sdo_r;
  assign link.sda_dev_oe = oe_r;
  assign amp_override    = ampo_r;
  assign amp_level       = ampl_r;

  // Output gating on the buffered clock, one lane per output
  for (genvar g = 0; g < cbo_pkg::NUM_OUT; g++) begin : g_lane
    logic [1:0] en_s_r;    // Register bit synchroniser
    logic [1:0] pin_s_r;   // Enable pin synchroniser
    logic       run_r;     // Lane allowed to run
    logic       run_nxt;
    logic       ck_r;      // Divided output clock
    logic       ck_nxt;
    always_comb begin
      run_nxt = en_s_r[1] && pin_s_r[1];
      // lane toggles on its own; starts only from low
      // finish the high phase, then hold low
      ck_nxt = run_r ? !ck_r : 1'b0;
    end
    // two sync stages plus run stage before first edge
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        en_s_r <= 2'h0;
        pin_s_r <= 2'h0;
        run_r <= 1'b0;
        ck_r <= 1'b0;
      end else begin
        en_s_r <= {en_s_r[0], en_r[g]};
        pin_s_r <= {pin_s_r[0], oe_pin[g]};
        run_r <= run_nxt;
        ck_r <= ck_nxt;
      end
    end
    assign clock_out[g] = ck_r;
  end
endmodule : cbo_target

// ==== cbo_ctrl.sv ====
// Two-wire controller for the clock buffer target.
// Assumes it is the only controller; it makes the link clock by division.
`timescale 1ns/1ps
module cbo_ctrl #(
  parameter int QUARTER = cbo_pkg::SCL_QUARTER_CYC  // Cycles per quarter bit
) (
  // Link
  cbo_link_if.host         link,
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Request
  input  wire logic        req,
  input  cbo_pkg::cbo_op_t op,
  input  wire logic [7:0]  cmd,
  input  wire logic [2:0]  len,
  input  wire logic [47:0] wdata,
  // Answer
  output logic             busy,
  output logic             done,
  output logic             nack_err,
  output logic [47:0]      rdata,
  output logic [7:0]       rcount
);
  typedef enum {H_IDLE, H_START, H_BYTE, H_RSTART, H_STOP} cbo_hst_t;

  logic [1:0] sda_s_r;  // Data synchroniser
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_s_r <= 2'h3;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
    end
  end

  cbo_hst_t         st_r, st_nxt;      // Controller state
  logic [15:0]      q_r, q_nxt;        // Quarter tick counter
  logic [1:0]       ph_r, ph_nxt;      // Quarter within bit
  logic [3:0]       bit_r, bit_nxt;    // Bit within byte, 8 is ack
  logic [7:0]       sh_r, sh_nxt;      // Shift register
  logic             rdm_r, rdm_nxt;    // Current byte is read
  logic             ackv_r, ackv_nxt;  // Refuse after this read byte
  logic             nak_r, nak_nxt;    // Sampled target ack level
  logic [3:0]       bn_r, bn_nxt;      // Byte number in transfer
  cbo_pkg::cbo_op_t op_r, op_nxt;      // Latched request
  logic [7:0]       cmd_r, cmd_nxt;
  logic [2:0]       len_r, len_nxt;
  logic [47:0]      wd_r, wd_nxt;
  logic             scl_r, scl_nxt;    // Link clock out
  logic             oe_r, oe_nxt;      // Pull data low
  logic             busy_r, busy_nxt;
  logic             done_r, done_nxt;
  logic             err_r, err_nxt;
  logic [47:0]      rd_r, rd_nxt;
  logic [7:0]       rc_r, rc_nxt;

  logic       rdop;   // Operation reads
  logic [3:0] lastb;  // Number of the final byte
  logic [3:0] nb;     // Next byte number
  logic       tick;   // Quarter elapsed
  assign rdop = (op_r == cbo_pkg::OP_BYTE_RD) || (op_r == cbo_pkg::OP_BLK_RD);
  assign nb   = 4'(bn_r + 4'h1);
  assign tick = (q_r == 16'(QUARTER - 1));
  always_comb begin
    case (op_r)
      cbo_pkg::OP_BYTE_WR: lastb = 4'h2;
      cbo_pkg::OP_BLK_WR:  lastb = 4'(4'h2 + {1'b0, len_r});
      cbo_pkg::OP_BYTE_RD: lastb = 4'h3;
      default:             lastb = 4'(4'h3 + {1'b0, len_r});
    endcase
  end

  // Byte to send as byte n of the transfer
  function automatic logic [7:0] txb(input logic [3:0] n, input cbo_pkg::cbo_op_t o,
                                     input logic [7:0] c, input logic [2:0] l,
                                     input logic [47:0] w);
    logic blk;
    blk = (o == cbo_pkg::OP_BLK_WR) || (o == cbo_pkg::OP_BLK_RD);
    if (n == 4'h0) begin
      txb = {cbo_pkg::TGT_ADDR7, 1'b0};
    end else if (n == 4'h1) begin
      txb = blk ? {1'b1, c[6:0]} : c;
    end else if (o == cbo_pkg::OP_BYTE_RD || o == cbo_pkg::OP_BLK_RD) begin
      txb = {cbo_pkg::TGT_ADDR7, 1'b1};
    end else if (o == cbo_pkg::OP_BYTE_WR) begin
      txb = w[7:0];
    end else if (n == 4'h2) begin
      txb = {5'h00, l};
    end else begin
      txb = w[(int'(n) - 3) * 8 +: 8];
    end
  endfunction : txb

  // Controller next state
  always_comb begin
    st_nxt = st_r;
    q_nxt = 16'h0000;
    ph_nxt = ph_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rdm_nxt = rdm_r;
    ackv_nxt = ackv_r;
    nak_nxt = nak_r;
    bn_nxt = bn_r;
    op_nxt = op_r;
    cmd_nxt = cmd_r;
    len_nxt = len_r;
    wd_nxt = wd_r;
    scl_nxt = scl_r;
    oe_nxt = oe_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    err_nxt = err_r;
    rd_nxt = rd_r;
    rc_nxt = rc_r;
    if (st_r == H_IDLE) begin
      scl_nxt = 1'b1;
      oe_nxt = 1'b0;
      if (req) begin
        op_nxt = op;
        cmd_nxt = cmd;
        len_nxt = len;
        wd_nxt = wdata;
        err_nxt = 1'b0;
        rd_nxt = 48'h0;
        bn_nxt = 4'h0;
        ph_nxt = 2'h0;
        busy_nxt = 1'b1;
        st_nxt = H_START;
      end
    end else begin
      q_nxt = tick ? 16'h0000 : 16'(q_r + 16'h0001);
      if (tick) begin
        ph_nxt = 2'(ph_r + 2'h1);
        case (st_r)
          H_START, H_RSTART: begin
            if (ph_r == 2'h0) oe_nxt = (st_r == H_START);
            if (ph_r == 2'h1) scl_nxt = 1'b1;
            if (ph_r == 2'h2) oe_nxt = 1'b1;
            if (ph_r == 2'h3) begin
              scl_nxt = 1'b0;
              st_nxt = H_BYTE;
              bit_nxt = 4'h0;
              rdm_nxt = 1'b0;
              sh_nxt = txb(bn_r, op_r, cmd_r, len_r, wd_r);
            end
          end
          H_BYTE: begin
            if (ph_r == 2'h0) begin
              // msb first; refuse the last read byte
              if (bit_r < 4'h8) oe_nxt = !rdm_r && !sh_r[7];
              else oe_nxt = rdm_r && !ackv_r;
            end
            if (ph_r == 2'h1) scl_nxt = 1'b1;
            if (ph_r == 2'h2) begin
              if (bit_r < 4'h8) begin
                if (rdm_r) sh_nxt = {sh_r[6:0], sda_s_r[1]};
              end else begin
                nak_nxt = sda_s_r[1];
              end
            end
            if (ph_r == 2'h3) begin
              scl_nxt = 1'b0;
              if (bit_r < 4'h8) begin
                if (!rdm_r) sh_nxt = {sh_r[6:0], 1'b0};
                bit_nxt = 4'(bit_r + 4'h1);
              end else if (!rdm_r && nak_r) begin
                err_nxt = 1'b1;
                st_nxt = H_STOP;
              end else begin
                // first block read byte is the count
                if (rdm_r && op_r == cbo_pkg::OP_BLK_RD && bn_r == 4'h3) rc_nxt = sh_r;
                else if (rdm_r) rd_nxt = {rd_r[39:0], sh_r};
                if (bn_r == lastb) begin
                  st_nxt = H_STOP;
                end else if (bn_r == 4'h1 && rdop) begin
                  bn_nxt = nb;
                  st_nxt = H_RSTART;
                end else begin
                  bn_nxt = nb;
                  bit_nxt = 4'h0;
                  rdm_nxt = rdop && (nb >= 4'h3);
                  ackv_nxt = (nb == lastb);
                  sh_nxt = txb(nb, op_r, cmd_r, len_r, wd_r);
                end
              end
            end
          end
          H_STOP: begin
            if (ph_r == 2'h0) oe_nxt = 1'b1;
            if (ph_r == 2'h1) scl_nxt = 1'b1;
            if (ph_r == 2'h2) oe_nxt = 1'b0;
            if (ph_r == 2'h3) begin
              st_nxt = H_IDLE;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
            end
          end
          default: begin
            st_nxt = H_IDLE;
          end
        endcase
      end
    end
  end

  // Controller registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= H_IDLE;
      q_r <= 16'h0000;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rdm_r <= 1'b0;
      ackv_r <= 1'b0;
      nak_r <= 1'b0;
      bn_r <= 4'h0;
      op_r <= cbo_pkg::OP_BYTE_WR;
      cmd_r <= 8'h00;
      len_r <= 3'h0;
      wd_r <= 48'h0;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rd_r <= 48'h0;
      rc_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      q_r <= q_nxt;
      ph_r <= ph_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rdm_r <= rdm_nxt;
      ackv_r <= ackv_nxt;
      nak_r <= nak_nxt;
      bn_r <= bn_nxt;
      op_r <= op_nxt;
      cmd_r <= cmd_nxt;
      len_r <= len_nxt;
      wd_r <= wd_nxt;
      scl_r <= scl_nxt;
      oe_r <= oe_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      rd_r <= rd_nxt;
      rc_r <= rc_nxt;
    end
  end

  assign link.scl         = scl_r;
  assign link.sda_host_o  = 1'b0;
  assign link.sda_host_oe = oe_r;
  assign busy     = busy_r;
  assign done     = done_r;
  assign nack_err = err_r;
  assign rdata    = rd_r;
  assign rcount   = rc_r;
endmodule : cbo_ctrl

// ==== cbo_link_properties.sv ====
// Checker for the two-wire link between controller and target.
// Assumes the controller runs with a quarter bit of 4 core cycles.
`timescale 1ns/1ps
module cbo_link_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_o,
  input wire logic sda_dev_oe,
  input wire logic sda_host_o,
  input wire logic sda_host_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Open drain: neither end may drive high
  property p_dev_drain; sda_dev_o == 1'b0; endproperty
  a_dev_drain: assert property (p_dev_drain)
    else $error("target drives data high");
  property p_host_drain; sda_host_o == 1'b0; endproperty
  a_host_drain: assert property (p_host_drain)
    else $error("controller drives data high");
  // Target moves data only while the clock is low
  property p_dev_edge; $changed(sda_dev_oe) |-> !scl; endproperty
  a_dev_edge: assert property (p_dev_edge)
    else $error("target data changed with clock high");
  // Start and stop come from the controller only
  property p_start_host; scl && $past(scl) && $fell(sda) |-> sda_host_oe; endproperty
  a_start_host: assert property (p_start_host)
    else $error("start not made by controller");
  property p_stop_host;
    scl && $past(scl) && $rose(sda) |-> $fell(sda_host_oe);
  endproperty
  a_stop_host: assert property (p_stop_host)
    else $error("stop not made by controller");
  // Clock low half bounded, high half long enough for sampling
  property p_scl_low; $fell(scl) |-> ##[1:16] scl; endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("link clock stuck low");
  property p_scl_high; $rose(scl) |-> scl [*6]; endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("link clock high half too short");
  // Target never holds the line past one byte and acknowledge
  property p_dev_release; $rose(sda_dev_oe) |-> ##[1:300] !sda_dev_oe; endproperty
  a_dev_release: assert property (p_dev_release)
    else $error("target holds data line");
  // Main scenarios seen
  c_start: cover property ($fell(sda) && scl);
  c_dev: cover property ($rose(sda_dev_oe));
  c_stop: cover property ($rose(sda) && scl);
endmodule : cbo_link_properties

// ==== clock_buffer_output_enable_ctrl_test.sv ====
// Testbench: controller and target joined by the link, checked end to end.
// Assumes a 100 MHz core clock and a free running 80 ns buffered clock.
`timescale 1ns/1ps
module clock_buffer_output_enable_ctrl_test;
  logic clk = 0, ref_clk = 0, resetn = 0, req = 0, pm_prog = 0;
  cbo_pkg::cbo_op_t op = cbo_pkg::OP_BYTE_WR;
  logic [7:0]  cmd = 8'h00, rcount;
  logic [2:0]  len = 3'h0, amp_level;
  logic [47:0] wdata = 48'h0, rdata;
  // enable pins driven from time zero
  logic [5:0]  oe_pin = 6'h3F, clock_out, c_or, c_and;
  logic        busy, done, nack_err, amp_override;
  int          error_cnt = 0, cmp_count = 0;
  always #5 clk = ~clk;
  always #40 ref_clk = ~ref_clk;
  cbo_link_if link ();
  cbo_ctrl #(.QUARTER(4)) cbo_ctrl_i (.link(link), .clk(clk), .resetn(resetn), .req(req),
    .op(op), .cmd(cmd), .len(len), .wdata(wdata), .busy(busy), .done(done),
    .nack_err(nack_err), .rdata(rdata), .rcount(rcount));
  cbo_target cbo_target_i (.link(link), .clk(clk), .resetn(resetn), .ref_clk(ref_clk),
    .oe_pin(oe_pin), .pm_prog(pm_prog), .clock_out(clock_out),
    .amp_override(amp_override), .amp_level(amp_level));
  cbo_link_properties cbo_link_properties_i (.clk(clk), .resetn(resetn), .scl(link.scl),
    .sda(link.sda), .sda_dev_o(link.sda_dev_o), .sda_dev_oe(link.sda_dev_oe),
    .sda_host_o(link.sda_host_o), .sda_host_oe(link.sda_host_oe));
  // Compare one value, count and report
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One controller transfer, bounded wait on done
  task automatic xfer(input cbo_pkg::cbo_op_t o, input logic [7:0] c, input logic [2:0] l,
                      input logic [47:0] w);
    int n;
    n = 0;
    @(posedge clk);
    op <= o;
    cmd <= c;
    len <= l;
    wdata <= w;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk(busy, 1'b1);
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 5000);
    if (n >= 5000) error_cnt++;
    chk(busy, 1'b0);
  endtask : xfer
  // Lanes that toggle in 400 ns; none may stay high
  task automatic lanes(input logic [5:0] exp_or);
    c_or = 6'h00;
    c_and = 6'h3F;
    repeat (40) begin
      @(negedge clk);
      c_or |= clock_out;
      c_and &= clock_out;
    end
    chk(c_or, exp_or);
    chk(c_and, 6'h00);
  endtask : lanes
  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("TB: %0d checks, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    xfer(cbo_pkg::OP_BLK_RD, 8'h80, 3'h6, 48'h0);
    chk(rcount, 8'h06);
    chk(rdata, 48'h0015E05A06D8);
    chk({amp_override, amp_level}, 4'hD);
    $display("TB: defaults test done");
    // Enable byte locked outside program mode
    xfer(cbo_pkg::OP_BYTE_WR, 8'h01, 3'h0, 48'h00);
    xfer(cbo_pkg::OP_BYTE_RD, 8'h01, 3'h0, 48'h0);
    chk(rdata, 48'h15);
    @(posedge clk);
    pm_prog <= 1'b1;
    xfer(cbo_pkg::OP_BYTE_WR, 8'h01, 3'h0, 48'hEA);
    xfer(cbo_pkg::OP_BYTE_RD, 8'h01, 3'h0, 48'h0);
    chk(rdata, 48'hEA);
    chk(nack_err, 1'b0);
    lanes(6'h38);
    // Pin low stops lane 5 only, pin high restarts it
    @(posedge clk);
    oe_pin <= 6'h1F;
    repeat (50) @(posedge clk);
    lanes(6'h18);
    @(posedge clk);
    oe_pin <= 6'h3F;
    repeat (55) @(posedge clk);
    lanes(6'h38);
    $display("TB: enable test done");
    // Block write from byte 2 upward, then read back
    xfer(cbo_pkg::OP_BLK_WR, 8'h82, 3'h4, 48'h2F04A540);
    chk(nack_err, 1'b0);
    lanes(6'h10);
    xfer(cbo_pkg::OP_BLK_RD, 8'h82, 3'h4, 48'h0);
    chk(rcount, 8'h04);
    chk(rdata, 48'h40A5042F);
    chk({amp_override, amp_level}, 4'h2);
    $display("TB: block test done");
    give_verdict();
  end
  // Watchdog well past the expected run
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule : clock_buffer_output_enable_ctrl_test
